// [src/dcc_dma_ctrl.sv]
/*
 * Eight-channel DMA control with a shared CRC or checksum unit.
 * Assumes an APB master, a word source stream and a word destination
 * stream; events arrive as one-cycle pulses synchronous to clk_i.
 */
// Implementation choices: the register offsets and the APB interface to the registers.
// How it works
// RULE1: Append mode: CRC channel data feeds CRC only; CRC written to destination start.
// RULE2: Without append, data passes the CRC and goes out in chosen byte order.
// RULE3: Type bit set picks IP header checksum, clear picks LFSR CRC.
// RULE4: Three-bit select attaches the CRC unit to that channel number.
// RULE5: Write byte order set forbids append mode; the append bit stays clear.
// RULE6: Ignore byte counts as a pattern match when ignore enable is set.
// RULE7: Busy reads one while channel enabled or active, else zero.
// RULE8: Pattern length bit picks two-byte pattern when set, one byte when clear.
// RULE9: Chain direction set: enabled by next higher channel; clear: next lower.
// RULE10: Chaining acts only when the channel's chain enable bit is one.
// RULE11: Enable bit runs the channel; clearing it suspends the channel.
// RULE12: Allow-events bit keeps start and abort events while disabled.
// RULE13: Suspension completes the word in flight; software polls busy.
// RULE14: Unimplemented control bits, including bits 23 to 16, read zero.
// RULE15: Priority field bits 1:0 read and write; writable bits reset zero.
`timescale 1ns/1ps
module dcc_dma_ctrl #(
	parameter int DEPTH = 8,
	parameter logic [31:0] CRC_POLY = 32'h04C1_1DB7
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [dcc_pkg::AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Channel events.
	input wire logic [dcc_pkg::NCH-1:0] start_evt_i,
	input wire logic [dcc_pkg::NCH-1:0] abort_evt_i,
	output logic [dcc_pkg::NCH-1:0] done_o,
	// Source stream.
	input wire logic src_valid_i,
	input wire logic [31:0] src_data_i,
	input wire logic src_last_i,
	output logic src_ready_o,
	// Destination stream.
	output logic dst_valid_o,
	output logic [31:0] dst_addr_o,
	output logic [31:0] dst_data_o,
	input wire logic dst_ready_i
);
	import dcc_pkg::*;

	logic [31:0] ctl [NCH];
	logic [31:0] dsa [NCH];
	logic [16:0] pat [NCH];
	logic [7:0] crc_ctl;
	logic [31:0] crc_acc;
	logic [31:0] crc_val;
	logic [31:0] ptr;
	logic [2:0] act;
	dcc_state_type state;
	dcc_state_type next_state;
	logic [NCH-1:0] en;
	logic [NCH-1:0] busy;
	logic [NCH-1:0] start_rec;
	logic [NCH-1:0] abort_rec;
	logic [NCH-1:0] chain_set;
	logic [NCH-1:0] pend;
	logic [3:0] pick_r;
	logic wr;
	logic setup;
	logic ch_hit;
	logic [2:0] widx;
	logic accept;
	logic app_case;
	logic crc_on;
	logic pmatch;
	logic xfer_end;
	logic done_ev;
	logic launch;
	logic fifo_wr;
	logic fifo_rdy;
	logic fifo_room2;
	logic [31:0] fifo_data;
	logic [31:0] rdata;
	logic rerr;

	function automatic logic byte_match(input logic [7:0] b, input logic [7:0] p,
		input logic [7:0] ign, input logic ign_en);
		byte_match = (b == p) || (ign_en && b == ign);
	endfunction : byte_match

	function automatic logic [31:0] lfsr_step(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int k = 31; k >= 0; k--)
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[k]) ? CRC_POLY : 32'h0000_0000);
		lfsr_step = r;
	endfunction : lfsr_step

	function automatic logic [31:0] sum_step(input logic [31:0] c, input logic [31:0] d);
		logic [16:0] s;
		s = {1'b0, c[15:0]} + {1'b0, d[31:16]};
		s = {1'b0, s[15:0]} + {16'h0000, s[16]};
		s = {1'b0, s[15:0]} + {1'b0, d[15:0]};
		s = {1'b0, s[15:0]} + {16'h0000, s[16]};
		sum_step = {16'h0000, s[15:0]};
	endfunction : sum_step

	// Highest priority field wins; ties go to the lower channel number.
	function automatic logic [3:0] pick(input logic [NCH-1:0] req, input logic [1:0] pr [NCH]);
		logic [3:0] r;
		logic [1:0] best;
		r = 4'h0;
		best = 2'b00;
		for (int k = NCH - 1; k >= 0; k--)
			if (req[k] && (!r[3] || pr[k] >= best))
			begin
				r = {1'b1, 3'(k)};
				best = pr[k];
			end
		pick = r;
	endfunction : pick

	always_comb
	begin
		logic [1:0] pr [NCH];
		for (int i = 0; i < NCH; i++)
		begin
			pr[i] = ctl[i][1:0];
			en[i] = ctl[i][BIT_EN];
			busy[i] = en[i] || ((state == DCC_XFER || state == DCC_CRCW) && act == 3'(i)); // see RULE7
			start_rec[i] = start_evt_i[i] && (en[i] || ctl[i][BIT_AED]); // see RULE12
			abort_rec[i] = abort_evt_i[i] && (en[i] || ctl[i][BIT_AED]); // see RULE12
			pend[i] = en[i] && ctl[i][BIT_EDET];
		end
		pick_r = pick(pend, pr);
	end

	assign setup = psel_i && !penable_i;
	assign wr = psel_i && penable_i && pwrite_i && pready_o;
	assign ch_hit = paddr_i[11:7] == OFS_CH_PAGE;
	assign widx = paddr_i[6:4];
	assign app_case = crc_ctl[BIT_APP] && act == crc_ctl[2:0]; // see RULE1
	assign crc_on = act == crc_ctl[2:0]; // see RULE4
	assign crc_val = crc_ctl[BIT_TYP] ? {16'h0000, ~crc_acc[15:0]} : crc_acc; // see RULE3
	assign accept = state == DCC_XFER && src_ready_o && src_valid_i;
	// A block ends on its last word or on a pattern hit when terminate mode is on.
	assign pmatch = pat[act][BIT_PAT_ON]
		&& byte_match(src_data_i[7:0], pat[act][7:0], ctl[act][31:24], ctl[act][BIT_IGN_EN])
		&& (!ctl[act][BIT_PAT_LEN] // see RULE8
		|| byte_match(src_data_i[15:8], pat[act][15:8], ctl[act][31:24],
		ctl[act][BIT_IGN_EN])); // see RULE6
	assign xfer_end = accept && (src_last_i || pmatch);
	assign done_ev = (state == DCC_XFER && !abort_rec[act] && xfer_end && !app_case)
		|| (state == DCC_CRCW && fifo_rdy);
	assign launch = state == DCC_IDLE && pick_r[3];
	assign fifo_wr = (accept && !app_case && !abort_rec[act]) || state == DCC_CRCW; // see RULE1
	assign fifo_data = (state == DCC_CRCW) ? crc_val
		: (crc_on && crc_ctl[BIT_WBO]) ? {<<8{src_data_i}} : src_data_i; // see RULE2

	always_comb
	begin
		for (int j = 0; j < NCH; j++)
			chain_set[j] = done_ev && ctl[j][BIT_CHN_EN] // see RULE10
				&& (ctl[j][BIT_CHN_DIR] ? (int'(act) == j + 1) : (int'(act) + 1 == j)); // see RULE9
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			DCC_IDLE:
				if (launch)
					next_state = DCC_XFER;
			DCC_XFER:
				if (abort_rec[act])
					next_state = DCC_IDLE;
				else if (xfer_end)
					next_state = app_case ? DCC_CRCW : DCC_IDLE;
				else if (!en[act])
					next_state = DCC_SUSP; // see RULE11
			DCC_SUSP:
				if (abort_rec[act])
					next_state = DCC_IDLE;
				else if (en[act])
					next_state = DCC_XFER;
			DCC_CRCW:
				if (fifo_rdy)
					next_state = DCC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state <= DCC_IDLE;
			act <= 3'h0;
			src_ready_o <= 1'b0;
			done_o <= '0;
		end
		else
		begin
			state <= next_state;
			if (launch)
				act <= pick_r[2:0];
			// The word already offered completes before suspension takes hold.
			src_ready_o <= next_state == DCC_XFER && fifo_room2
				&& (state != DCC_IDLE || launch); // see RULE13
			done_o <= done_ev ? NCH'(1) << act : '0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ptr <= 32'h0000_0000;
		else if (launch)
			ptr <= dsa[pick_r[2:0]];
		else if (state == DCC_CRCW)
			ptr <= dsa[act]; // see RULE1
		else if (fifo_wr && fifo_rdy)
			ptr <= ptr + ADDR_STEP;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			crc_acc <= LFSR_SEED;
		else if (launch && pick_r[2:0] == crc_ctl[2:0])
			crc_acc <= crc_ctl[BIT_TYP] ? SUM_SEED : LFSR_SEED;
		else if (accept && crc_on)
			crc_acc <= crc_ctl[BIT_TYP] ? sum_step(crc_acc, src_data_i)
				: lfsr_step(crc_acc, src_data_i); // see RULE3
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			crc_ctl <= CRC_CTRL_RST;
		else if (wr && paddr_i == OFS_CRC_CTRL)
		begin
			crc_ctl <= pwdata_i[7:0] & CRC_CTRL_WMASK;
			crc_ctl[BIT_APP] <= pwdata_i[BIT_APP] && !pwdata_i[BIT_WBO]; // see RULE5
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			for (int i = 0; i < NCH; i++)
			begin
				ctl[i] <= CH_CTRL_RST; // see RULE15
				dsa[i] <= 32'h0000_0000;
				pat[i] <= CH_PAT_RST;
			end
		else
			for (int i = 0; i < NCH; i++)
			begin
				if (wr && ch_hit && widx == 3'(i) && paddr_i[3:0] == OFS_CH_CTRL)
				begin
					ctl[i][31:BIT_EDET+1] <= pwdata_i[31:BIT_EDET+1]
						& CH_CTRL_WMASK[31:BIT_EDET+1]; // see RULE14
					ctl[i][1:0] <= pwdata_i[1:0]; // see RULE15
				end
				if (wr && ch_hit && widx == 3'(i) && paddr_i[3:0] == OFS_CH_DEST)
					dsa[i] <= pwdata_i;
				if (wr && ch_hit && widx == 3'(i) && paddr_i[3:0] == OFS_CH_PAT)
					pat[i] <= pwdata_i[16:0];
				if ((done_ev && act == 3'(i) && !ctl[i][BIT_AEN]) || abort_rec[i])
					ctl[i][BIT_EN] <= 1'b0;
				if (chain_set[i])
					ctl[i][BIT_EN] <= 1'b1; // see RULE9
				// A start arriving with the clear still records.
				if (start_rec[i])
					ctl[i][BIT_EDET] <= 1'b1;
				else if (abort_rec[i] || (launch && pick_r[2:0] == 3'(i)))
					ctl[i][BIT_EDET] <= 1'b0;
			end
	end

	always_comb
	begin
		rdata = 32'h0000_0000;
		rerr = 1'b0;
		if (paddr_i == OFS_CRC_CTRL)
			rdata = {24'h00_0000, crc_ctl};
		else if (paddr_i == OFS_CRC_RESULT)
			rdata = crc_val;
		else if (ch_hit && paddr_i[3:0] == OFS_CH_CTRL)
		begin
			rdata = ctl[widx] & (CH_CTRL_WMASK | (32'h1 << BIT_EDET)); // see RULE14
			rdata[BIT_BUSY] = busy[widx]; // see RULE7
		end
		else if (ch_hit && paddr_i[3:0] == OFS_CH_DEST)
			rdata = dsa[widx];
		else if (ch_hit && paddr_i[3:0] == OFS_CH_PAT)
			rdata = {15'h0000, pat[widx]};
		else
			rerr = 1'b1;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
			pready_o <= 1'b0;
		end
		else
		begin
			pready_o <= 1'b1;
			if (setup)
			begin
				prdata_o <= pwrite_i ? 32'h0000_0000 : rdata;
				pslverr_o <= rerr;
			end
		end
	end

	dcc_fifo #(
		.W(64),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(fifo_wr),
		.in_ready_o(fifo_rdy),
		.in_data_i({ptr, fifo_data}),
		.room2_o(fifo_room2),
		.out_valid_o(dst_valid_o),
		.out_ready_i(dst_ready_i),
		.out_data_o({dst_addr_o, dst_data_o})
	);

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_append_no_write: assert property (accept && app_case |-> !fifo_wr) // see RULE1
		else $error("append mode wrote source data");
	a_crc_to_dest: assert property (state == DCC_CRCW && fifo_rdy |-> ptr == dsa[act]) // see RULE1
		else $error("CRC not aimed at destination start");
	a_pass_write: assert property (accept && !app_case && !abort_rec[act] |-> fifo_wr && fifo_rdy)
		else $error("pass-through word not written"); // see RULE2
	a_sum_width: assert property (accept && crc_on && crc_ctl[BIT_TYP] |=> crc_acc[31:16] == 16'h0000)
		else $error("checksum spilled over 16 bits"); // see RULE3
	a_crc_select: assert property (accept && !crc_on && !launch |=> $stable(crc_acc)) // see RULE4
		else $error("CRC moved for unselected channel");
	a_wbo_blocks: assert property (crc_ctl[BIT_WBO] |-> !crc_ctl[BIT_APP]) // see RULE5
		else $error("append set with byte order one");
	a_busy_track: assert property (en[0] || (state == DCC_XFER && act == 3'h0) |-> busy[0])
		else $error("busy low while channel 0 enabled"); // see RULE7
	a_chain_next: assert property (done_ev && act == 3'h1 && ctl[2][BIT_CHN_EN] && !ctl[2][BIT_CHN_DIR]
		|=> en[2]) else $error("chain from channel 1 failed"); // see RULE9
	a_chain_off: assert property (done_ev && !ctl[3][BIT_CHN_EN] && !en[3] && !wr |=> !en[3])
		else $error("unchained channel got enabled"); // see RULE10
	a_event_drop: assert property (start_evt_i[0] && !en[0] && !ctl[0][BIT_AED] && !ctl[0][BIT_EDET]
		|=> !ctl[0][BIT_EDET]) else $error("event kept while disabled"); // see RULE12
	a_suspend_soon: assert property (state == DCC_XFER && !en[act] |=> state != DCC_XFER)
		else $error("channel kept running after disable"); // see RULE11
	a_rsvd_zero: assert property (setup && ch_hit && paddr_i[3:0] == OFS_CH_CTRL && !pwrite_i
		|=> prdata_o[23:16] == 8'h00) else $error("reserved control bits read nonzero"); // see RULE14
endmodule : dcc_dma_ctrl

// [src/dcc_fifo.sv]
/*
 * Word FIFO with a registered output stage.
 * Assumes one clock; ready and valid handshake on both sides.
 */
`timescale 1ns/1ps
module dcc_fifo #(
	parameter int W = 64,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Filling side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic room2_o,
	// Draining side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = count < (PW+1)'(DEPTH);
	assign room2_o = count < (PW+1)'(DEPTH - 1);
	assign push = in_valid_i && in_ready_o;
	assign pop = (count != '0) && (!out_valid_o || out_ready_i);

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
			begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
				out_data_o <= mem[rd_ptr];
			end
			if (pop)
				out_valid_o <= 1'b1;
			else if (out_ready_i)
				out_valid_o <= 1'b0;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : dcc_fifo

// [src/dcc_pkg.sv]
/*
 * Constants shared by the DMA channel control and CRC selection block.
 * Assumes a 12-bit APB byte address with each register on an aligned word.
 */
package dcc_pkg;
	localparam int NCH = 8;
	localparam int AW = 12;
	localparam logic [11:0] OFS_CRC_CTRL = 12'h000;
	localparam logic [11:0] OFS_CRC_RESULT = 12'h004;
	localparam logic [4:0] OFS_CH_PAGE = 5'h02;
	localparam logic [3:0] OFS_CH_CTRL = 4'h0;
	localparam logic [3:0] OFS_CH_DEST = 4'h4;
	localparam logic [3:0] OFS_CH_PAT = 4'h8;
	localparam int BIT_IGN_LO = 24;
	localparam int BIT_BUSY = 15;
	localparam int BIT_IGN_EN = 13;
	localparam int BIT_PAT_LEN = 11;
	localparam int BIT_CHN_DIR = 8;
	localparam int BIT_EN = 7;
	localparam int BIT_AED = 6;
	localparam int BIT_CHN_EN = 5;
	localparam int BIT_AEN = 4;
	localparam int BIT_EDET = 2;
	localparam int BIT_WBO = 7;
	localparam int BIT_APP = 6;
	localparam int BIT_TYP = 5;
	localparam int BIT_PAT_ON = 16;
	localparam logic [31:0] CH_CTRL_WMASK = 32'hFF00_29F3;
	localparam logic [7:0] CRC_CTRL_WMASK = 8'hE7;
	localparam logic [31:0] CH_CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] CRC_CTRL_RST = 8'h00;
	localparam logic [16:0] CH_PAT_RST = 17'h0_0000;
	localparam logic [31:0] LFSR_SEED = 32'hFFFF_FFFF;
	localparam logic [31:0] SUM_SEED = 32'h0000_0000;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	typedef enum logic [1:0] {
		DCC_IDLE = 2'b00,
		DCC_XFER = 2'b01,
		DCC_SUSP = 2'b10,
		DCC_CRCW = 2'b11
	} dcc_state_type;
endpackage : dcc_pkg

// [tb/dcc_mem_model.sv]
/*
 * Source and destination memory model for the DMA channel block.
 * Assumes one clock; the bench queues source words before a channel starts.
 */
`timescale 1ns/1ps
module dcc_mem_model (
	// Clock.
	input wire logic clk_i,
	// Source side.
	output logic src_valid_o,
	output logic [31:0] src_data_o,
	output logic src_last_o,
	input wire logic src_ready_i,
	// Destination side.
	input wire logic dst_valid_i,
	input wire logic [31:0] dst_addr_i,
	input wire logic [31:0] dst_data_i,
	output logic dst_ready_o
);
	logic [32:0] src_q[$];
	logic [63:0] got_q[$];
	initial
	begin
		src_valid_o = 1'b0;
		src_data_o = 32'h0000_0000;
		src_last_o = 1'b0;
		dst_ready_o = 1'b0;
	end
	// An idle source inverts every data bit each cycle, so stale data never looks fresh.
	always @(posedge clk_i)
	begin
		if (src_valid_o && src_ready_i)
			void'(src_q.pop_front());
		if (src_q.size() > 0)
		begin
			src_valid_o <= 1'b1;
			{src_last_o, src_data_o} <= src_q[0];
		end
		else
		begin
			src_valid_o <= 1'b0;
			src_last_o <= 1'b0;
			src_data_o <= ~src_data_o;
		end
	end
	// The sink stalls on every other cycle.
	always @(posedge clk_i)
	begin
		if (dst_valid_i && dst_ready_o)
			got_q.push_back({dst_addr_i, dst_data_i});
		dst_ready_o <= ~dst_ready_o;
	end
endmodule : dcc_mem_model

// [tb/dma_channel_control_crc_tb.sv]
/*
 * Self-checking bench for the DMA channel control and CRC selection block.
 * Assumes the zero-wait APB slave and the memory model beside it.
 */
`timescale 1ns/1ps
module dma_channel_control_crc_tb;
	import dcc_pkg::*;
	localparam logic [31:0] POLY = 32'h04C1_1DB7;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, src_data, dst_addr, dst_data;
	logic [7:0] start_evt, abort_evt, done;
	logic src_valid, src_last, src_ready, dst_valid, dst_ready;
	int done_cnt[8];
	int mismatches = 0;
	int checks = 0;
	always #25 clk_i = ~clk_i;
	dcc_dma_ctrl #(.DEPTH(8), .CRC_POLY(POLY)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.start_evt_i(start_evt), .abort_evt_i(abort_evt), .done_o(done),
		.src_valid_i(src_valid), .src_data_i(src_data), .src_last_i(src_last),
		.src_ready_o(src_ready), .dst_valid_o(dst_valid), .dst_addr_o(dst_addr),
		.dst_data_o(dst_data), .dst_ready_i(dst_ready));
	dcc_mem_model mem (.clk_i(clk_i), .src_valid_o(src_valid), .src_data_o(src_data),
		.src_last_o(src_last), .src_ready_i(src_ready), .dst_valid_i(dst_valid),
		.dst_addr_i(dst_addr), .dst_data_i(dst_data), .dst_ready_o(dst_ready));
	always @(posedge clk_i)
		for (int i = 0; i < 8; i++)
			if (done[i] === 1'b1)
				done_cnt[i]++;
	function automatic logic [11:0] ca(input int n, input logic [3:0] o);
		return {OFS_CH_PAGE, n[2:0], o};
	endfunction : ca
	function automatic logic [31:0] lfsr(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--)
			r = {r[30:0], 1'b0} ^ (((r[31] ^ d[i]) == 1'b1) ? POLY : 32'h0000_0000);
		return r;
	endfunction : lfsr
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		// The wait for the slave's answer ends once pready is one; only the watchdog bounds it.
		while (pready !== 1'b1)
			@(posedge clk_i);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r, x);
	endtask : rd
	task automatic kick(input logic [7:0] s, input logic [7:0] a);
		start_evt <= s;
		abort_evt <= a;
		@(posedge clk_i);
		start_evt <= 8'h00;
		abort_evt <= 8'h00;
		@(posedge clk_i);
	endtask : kick
	task automatic run(input int ch, input logic [31:0] ctrl, input int nexp);
		int n;
		int d0;
		n = 0;
		d0 = done_cnt[ch];
		mem.got_q.delete();
		wr(ca(ch, OFS_CH_CTRL), ctrl | 32'h0000_0080);
		kick(8'(1 << ch), 8'h00);
		while ((done_cnt[ch] == d0 || mem.got_q.size() < nexp) && n < 300)
		begin
			n++;
			@(posedge clk_i);
		end
		chk(32'(mem.got_q.size()), 32'(nexp));
		rd(ca(ch, OFS_CH_CTRL), ctrl);
	endtask : run
	task automatic ckw(input int i, input logic [31:0] a, input logic [31:0] d);
		chk(mem.got_q[i][63:32], a);
		chk(mem.got_q[i][31:0], d);
	endtask : ckw
	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial
	begin
		logic [31:0] r;
		logic e;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{start_evt, abort_evt} = '0;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(OFS_CRC_CTRL, 32'h0000_0000);
		rd(ca(0, OFS_CH_CTRL), 32'h0000_0000);
		wr(ca(2, OFS_CH_CTRL), 32'hFFFF_FF7F);
		rd(ca(2, OFS_CH_CTRL), 32'hFF00_2973);
		wr(ca(2, OFS_CH_CTRL), 32'h0000_0080);
		rd(ca(2, OFS_CH_CTRL), 32'h0000_8080);
		wr(ca(2, OFS_CH_CTRL), 32'h0000_0000);
		rd(ca(2, OFS_CH_CTRL), 32'h0000_0000);
		apb(1'b0, 12'hFF0, 32'h0000_0000, r, e);
		chk(r, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		$display("register test done");
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_CRC_CTRL, 32'(i));
			rd(OFS_CRC_CTRL, 32'(i));
		end
		wr(OFS_CRC_CTRL, 32'h0000_00FF);
		rd(OFS_CRC_CTRL, 32'h0000_00A7);
		wr(OFS_CRC_CTRL, 32'h0000_0047);
		rd(OFS_CRC_CTRL, 32'h0000_0047);
		$display("crc control test done");
		kick(8'h02, 8'h00);
		rd(ca(1, OFS_CH_CTRL), 32'h0000_0000);
		wr(ca(1, OFS_CH_CTRL), 32'h0000_0040);
		kick(8'h02, 8'h00);
		rd(ca(1, OFS_CH_CTRL), 32'h0000_0044);
		kick(8'h00, 8'h02);
		rd(ca(1, OFS_CH_CTRL), 32'h0000_0040);
		$display("event test done");
		wr(OFS_CRC_CTRL, 32'h0000_0003);
		wr(ca(0, OFS_CH_DEST), 32'h0000_1000);
		wr(ca(1, OFS_CH_CTRL), 32'h0000_0120);
		mem.src_q = '{{1'b0, 32'hA1A2_A3A4}, {1'b0, 32'hB1B2_B3B4}, {1'b1, 32'hC1C2_C3C4}};
		run(0, 32'h0000_0000, 3);
		ckw(0, 32'h0000_1000, 32'hA1A2_A3A4);
		ckw(2, 32'h0000_1008, 32'hC1C2_C3C4);
		rd(ca(1, OFS_CH_CTRL), 32'h0000_0120);
		// Byte order applies only to data passing the CRC unit, so attach it to channel 0.
		wr(OFS_CRC_CTRL, 32'h0000_0080);
		wr(ca(1, OFS_CH_CTRL), 32'h0000_0000);
		mem.src_q = '{{1'b0, 32'h1122_3344}, {1'b1, 32'h5566_7788}};
		run(0, 32'h0000_0000, 2);
		ckw(1, 32'h0000_1004, 32'h8877_6655);
		rd(ca(1, OFS_CH_CTRL), 32'h0000_0000);
		$display("pass-through test done");
		wr(OFS_CRC_CTRL, 32'h0000_0040);
		wr(ca(1, OFS_CH_CTRL), 32'h0000_0020);
		mem.src_q = '{{1'b0, 32'h1234_5678}, {1'b1, 32'h9ABC_DEF0}};
		run(0, 32'h0000_0000, 1);
		ckw(0, 32'h0000_1000, lfsr(lfsr(LFSR_SEED, 32'h1234_5678), 32'h9ABC_DEF0));
		rd(ca(1, OFS_CH_CTRL), 32'h0000_80A0);
		wr(OFS_CRC_CTRL, 32'h0000_0060);
		mem.src_q = '{{1'b0, 32'h0001_0002}, {1'b1, 32'h0003_0004}};
		run(0, 32'h0000_0000, 1);
		chk(mem.got_q[0][63:32], 32'h0000_1000);
		chk(mem.got_q[0][31:0] & 32'h0000_FFFF, 32'h0000_FFF5);
		$display("append test done");
		wr(OFS_CRC_CTRL, 32'h0000_0003);
		wr(ca(0, OFS_CH_PAT), 32'h0001_AA55);
		mem.src_q = '{{1'b0, 32'h0000_3355}, {1'b0, 32'h0000_7755}};
		run(0, 32'h7700_2800, 2);
		mem.src_q = '{{1'b0, 32'h0000_0155}};
		run(0, 32'h0000_0000, 1);
		$display("pattern test done");
		tally_and_finish();
	end
endmodule : dma_channel_control_crc_tb
